// ### hw/mbac_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbac_regs.svh"
// How it works
// - mode comes from program status high and two internal mode bits.
// - sixty-four segments hold rights, first, last, offset and register rights.
// - a segment with no rights at all is disabled and never matches.
// - every address is checked, and in user mode translated, before memory is driven.
// - register access is decided by mode, in user mode also by segment.
// - denied register reads return zero, denied writes are dropped.
// - boot and contactless: test ROM rx, reserved EEPROM rwx, RAM rw.
// - test mode: whole ROM rx, whole EEPROM rwx, whole RAM rw.
// - system mode: application ROM rx, EEPROM rwx, RAM rw, no segments.
// - user mode: application memories only as the matching segment permits.
// - boot and contactless may also read the security row.
// - coprocessor reads EEPROM and reads or writes its own RAM.
// - boot and test code reach every register group except segment config.
// - contactless code reaches hardware-component and general registers, and reads program status high.
// - system code reaches segment config, system and hardware registers.
// - user hardware register rights come from the current fetch segment.
// - general CPU registers are open in every mode.
// - program status high is readable in user and contactless modes.
// - segment config registers are closed outside system mode.
// - the table pointer registers never read back.
// - random number register ignores every write.
// - cipher key register never reads back.
// - table pointer resets to zero, which disables all segments.
module mbac_top import mbac_pkg::*; (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic [7:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error
    input wire logic [1:0] core_mode_bits, // Internal mode bits
    input wire mbac_cpu_req_t cpu_req, // CPU memory request
    output mbac_mem_cmd_t mem_cmd, // Physical memory command
    input wire logic [7:0] mem_rdata, // Memory read data
    output logic [7:0] cpu_rdata, // Read data to CPU
    output logic cpu_rvalid, // Read data valid
    output logic cpu_deny, // Memory access denied
    input wire mbac_sfr_req_t sfr_req, // CPU register request
    input wire logic [7:0] sfr_fab_rdata, // Register fabric read data
    output mbac_sfr_wr_t sfr_fab_wr, // Register fabric write
    output logic [7:0] sfr_rdata, // Register read data to CPU
    output logic sfr_deny, // Register access denied
    input wire mbac_cop_req_t cop_req, // Coprocessor request
    output logic cop_grant, // Coprocessor access granted
    output mbac_mode_t cpu_mode // Current CPU mode
);
    mbac_state_t st_reg;
    mbac_state_t st_next;
    mbac_mode_t mode;
    logic tbl_on;
    logic [63:0] seg_hit;
    logic [5:0] hit_idx;
    mbac_seg_t hseg;
    mbac_seg_t cseg;
    logic [15:0] pa;
    logic rd, wr, fx;
    logic in_trom, in_arom, in_ree, in_aee, in_sec, in_ram, in_cram;
    logic app_ok, mem_ok;
    logic s_rd, s_wr, g_gen, g_seg, g_sys, g_tst, g_hw;
    logic is_program_status_high, is_plo, is_phi, is_rng, is_key, is_int;
    logic sfr_ok;
    logic apb_acc, apb_wr, mapped;
    // ********************************
    // Mode decode
    // ********************************
    always_comb begin
        case (core_mode_bits)
            `MBAC_MB_BOOT: mode = MODE_BOOT;
            `MBAC_MB_TEST: mode = MODE_TEST;
            `MBAC_MB_CTLS: mode = MODE_CTLS;
            default: mode = st_reg.program_status_high[`MBAC_PROGRAM_STATUS_HIGH_SYS_BIT] ? MODE_SYSTEM : MODE_USER;
        endcase
    end
    assign cpu_mode = mode;
    // ********************************
    // Segment match
    // ********************************
    // A zero pointer keeps the whole table dead until system software sets it
    assign tbl_on = (st_reg.ptr_lo != 8'h00) || (st_reg.ptr_hi != 8'h00);
    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_seg_match
            assign seg_hit[g] = tbl_on && (st_reg.seg[g].rights != 5'h00)
                && (cpu_req.vaddr >= st_reg.seg[g].first)
                && (cpu_req.vaddr <= st_reg.seg[g].last);
        end
    endgenerate
    // Lowest index wins when software lets segments overlap
    always_comb begin
        hit_idx = 6'h00;
        for (int i = 63; i >= 0; i--) begin
            if (seg_hit[i]) begin
                hit_idx = 6'(i);
            end
        end
    end
    assign hseg = st_reg.seg[hit_idx];
    assign cseg = st_reg.seg[st_reg.cur_seg];
    // ********************************
    // Memory permission
    // ********************************
    assign rd = cpu_req.op == OP_READ;
    assign wr = cpu_req.op == OP_WRITE;
    assign fx = cpu_req.op == OP_FETCH;
    assign pa = (mode == MODE_USER) ? 16'(cpu_req.vaddr + hseg.offset) : cpu_req.vaddr;
    assign in_trom = pa <= `MBAC_TROM_END;
    assign in_arom = (pa >= `MBAC_AROM_BASE) && (pa <= `MBAC_AROM_END);
    assign in_ree = (pa >= `MBAC_REE_BASE) && (pa <= `MBAC_REE_END);
    assign in_aee = (pa >= `MBAC_AEE_BASE) && (pa <= `MBAC_AEE_END);
    assign in_sec = (pa >= `MBAC_SECROW_BASE) && (pa <= `MBAC_SECROW_END);
    assign in_ram = (pa >= `MBAC_RAM_BASE) && (pa <= `MBAC_RAM_END);
    assign in_cram = pa >= `MBAC_COPRAM_BASE;
    assign app_ok = (in_arom && (rd || fx)) || in_aee || (in_ram && !fx);
    always_comb begin
        case (mode)
            MODE_BOOT, MODE_CTLS: mem_ok = (in_trom && (rd || fx)) || in_ree
                || (in_ram && !fx) || (in_sec && rd);
            MODE_TEST: mem_ok = ((in_trom || in_arom) && (rd || fx)) || in_ree || in_aee
                || ((in_ram || in_cram) && !fx);
            MODE_SYSTEM: mem_ok = app_ok;
            MODE_USER: mem_ok = app_ok && (seg_hit != 64'h0)
                && ((rd && hseg.rights[`MBAC_RT_R]) || (wr && hseg.rights[`MBAC_RT_W])
                || (fx && hseg.rights[`MBAC_RT_X]));
            default: mem_ok = 1'b0;
        endcase
    end
    // ********************************
    // Register permission
    // ********************************
    assign s_wr = sfr_req.wr;
    assign s_rd = sfr_req.rd && !sfr_req.wr;
    assign g_gen = (sfr_req.addr == `MBAC_SFR_ACC) || (sfr_req.addr == `MBAC_SFR_SP)
        || (sfr_req.addr == `MBAC_SFR_DPL) || (sfr_req.addr == `MBAC_SFR_DPH);
    assign g_seg = (sfr_req.addr >= `MBAC_SFR_SEGCFG_LO) && (sfr_req.addr <= `MBAC_SFR_SEGCFG_HI);
    assign g_sys = (sfr_req.addr >= `MBAC_SFR_SYS_LO) && (sfr_req.addr <= `MBAC_SFR_SYS_HI);
    assign g_tst = (sfr_req.addr >= `MBAC_SFR_TEST_LO) && (sfr_req.addr <= `MBAC_SFR_TEST_HI);
    assign g_hw = !g_gen && !g_seg && !g_sys && !g_tst;
    assign is_program_status_high = sfr_req.addr == `MBAC_SFR_PROGRAM_STATUS_HIGH;
    assign is_plo = sfr_req.addr == `MBAC_SFR_PTR_LO;
    assign is_phi = sfr_req.addr == `MBAC_SFR_PTR_HI;
    assign is_rng = sfr_req.addr == `MBAC_SFR_RNG;
    assign is_key = sfr_req.addr == `MBAC_SFR_KEY;
    assign is_int = is_program_status_high || is_plo || is_phi;
    always_comb begin
        case (mode)
            MODE_BOOT, MODE_TEST: sfr_ok = !g_seg;
            MODE_CTLS: sfr_ok = g_hw || (is_program_status_high && s_rd);
            MODE_SYSTEM: sfr_ok = g_seg || g_sys || g_hw;
            MODE_USER: sfr_ok = (g_hw && tbl_on && st_reg.cur_valid
                && ((s_rd && cseg.rights[`MBAC_RT_HR]) || (s_wr && cseg.rights[`MBAC_RT_HW])))
                || (is_program_status_high && s_rd);
            default: sfr_ok = 1'b0;
        endcase
        if (g_gen) begin
            sfr_ok = 1'b1;
        end
        if ((s_rd && (is_plo || is_phi)) || (s_wr && is_rng) || (s_rd && is_key)) begin
            sfr_ok = 1'b0;
        end
    end
    // ********************************
    // APB slave
    // ********************************
    assign pready = 1'b1;
    assign apb_acc = psel && penable;
    assign apb_wr = apb_acc && pwrite;
    assign mapped = (paddr == `MBAC_A_SEG_SEL) || (paddr == `MBAC_A_SEG_FIRST)
        || (paddr == `MBAC_A_SEG_LAST) || (paddr == `MBAC_A_SEG_OFFSET)
        || (paddr == `MBAC_A_SEG_RIGHTS) || (paddr == `MBAC_A_STATUS);
    assign pslverr = apb_acc && !mapped;
    always_comb begin
        prdata = 32'h0;
        if (apb_acc && !pwrite) begin
            case (paddr)
                `MBAC_A_SEG_SEL: prdata = {26'h0, st_reg.seg_sel};
                `MBAC_A_SEG_FIRST: prdata = {16'h0, st_reg.seg[st_reg.seg_sel].first};
                `MBAC_A_SEG_LAST: prdata = {16'h0, st_reg.seg[st_reg.seg_sel].last};
                `MBAC_A_SEG_OFFSET: prdata = {16'h0, st_reg.seg[st_reg.seg_sel].offset};
                `MBAC_A_SEG_RIGHTS: prdata = {27'h0, st_reg.seg[st_reg.seg_sel].rights};
                `MBAC_A_STATUS: begin
                    prdata[`MBAC_ST_DENY] = st_reg.deny_sticky;
                    prdata[`MBAC_ST_SEG_LSB +: 6] = st_reg.cur_seg;
                    prdata[`MBAC_ST_CUR_VALID] = st_reg.cur_valid;
                    prdata[`MBAC_ST_MODE_LSB +: 3] = 3'(mode);
                end
                default: prdata = 32'h0;
            endcase
        end
    end
    // ********************************
    // Next state
    // ********************************
    always_comb begin
        st_next = st_reg;
        if (apb_wr) begin
            case (paddr)
                `MBAC_A_SEG_SEL: st_next.seg_sel = pwdata[5:0];
                `MBAC_A_SEG_FIRST: st_next.seg[st_reg.seg_sel].first = pwdata[15:0];
                `MBAC_A_SEG_LAST: st_next.seg[st_reg.seg_sel].last = pwdata[15:0];
                `MBAC_A_SEG_OFFSET: st_next.seg[st_reg.seg_sel].offset = pwdata[15:0];
                `MBAC_A_SEG_RIGHTS: st_next.seg[st_reg.seg_sel].rights = pwdata[4:0];
                `MBAC_A_STATUS: begin
                    if (pwdata[`MBAC_ST_DENY]) begin
                        st_next.deny_sticky = 1'b0;
                    end
                end
                default: st_next.seg_sel = st_reg.seg_sel;
            endcase
        end
        // Memory path: the command only leaves on a grant
        st_next.mem = '0;
        st_next.cpu_deny = cpu_req.valid && !mem_ok;
        if (cpu_req.valid && mem_ok) begin
            st_next.mem.en = 1'b1;
            st_next.mem.we = wr;
            st_next.mem.fetch = fx;
            st_next.mem.paddr = pa;
            st_next.mem.wdata = cpu_req.wdata;
        end
        if (cpu_req.valid && mem_ok && fx && (mode == MODE_USER)) begin
            st_next.cur_seg = hit_idx;
            st_next.cur_valid = 1'b1;
        end
        st_next.rd_pend = cpu_req.valid && !wr;
        st_next.rd_gate = cpu_req.valid && !wr && mem_ok;
        st_next.cpu_rvalid = st_reg.rd_pend;
        st_next.cpu_rdata = st_reg.rd_gate ? mem_rdata : 8'h00;
        // Register path
        st_next.sfr_wr = '0;
        st_next.sfr_deny = (s_rd || s_wr) && !sfr_ok;
        st_next.sfr_rdata = 8'h00;
        if (s_rd && sfr_ok) begin
            st_next.sfr_rdata = is_program_status_high ? st_reg.program_status_high : sfr_fab_rdata;
        end
        if (s_wr && sfr_ok) begin
            if (is_program_status_high) begin
                st_next.program_status_high = sfr_req.wdata;
            end else if (is_plo) begin
                st_next.ptr_lo = sfr_req.wdata;
            end else if (is_phi) begin
                st_next.ptr_hi = sfr_req.wdata;
            end
            st_next.sfr_wr.en = !is_int;
            st_next.sfr_wr.addr = sfr_req.addr;
            st_next.sfr_wr.data = sfr_req.wdata;
        end
        // Coprocessor bypasses the mode checks
        st_next.cop_grant = cop_req.valid && ((!cop_req.we && (cop_req.addr >= `MBAC_REE_BASE)
            && (cop_req.addr <= `MBAC_AEE_END)) || (cop_req.addr >= `MBAC_COPRAM_BASE));
        // A new denial beats a clear in the same cycle
        if (st_next.cpu_deny || st_next.sfr_deny) begin
            st_next.deny_sticky = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.program_status_high <= `MBAC_PROGRAM_STATUS_HIGH_RST;
            st_reg.ptr_lo <= `MBAC_PTR_RST;
            st_reg.ptr_hi <= `MBAC_PTR_RST;
        end else begin
            st_reg <= st_next;
        end
    end
    assign mem_cmd = st_reg.mem;
    assign cpu_rdata = st_reg.cpu_rdata;
    assign cpu_rvalid = st_reg.cpu_rvalid;
    assign cpu_deny = st_reg.cpu_deny;
    assign sfr_fab_wr = st_reg.sfr_wr;
    assign sfr_rdata = st_reg.sfr_rdata;
    assign sfr_deny = st_reg.sfr_deny;
    assign cop_grant = st_reg.cop_grant;
    // ********************************
    // Assertions
    // ********************************
    property p_mode_boot;
        @(posedge pclk) disable iff (!presetn) (core_mode_bits == `MBAC_MB_BOOT)
            |-> (cpu_mode == MODE_BOOT);
    endproperty
    a_mode_boot: assert property (p_mode_boot) else $error("boot bits not decoded");
    property p_deny_no_mem;
        @(posedge pclk) disable iff (!presetn) cpu_deny |-> !mem_cmd.en;
    endproperty
    a_deny_no_mem: assert property (p_deny_no_mem) else $error("denied access hit memory");
    property p_denied_read_zero;
        @(posedge pclk) disable iff (!presetn) (cpu_req.valid && !wr && !mem_ok)
            |=> ##1 (cpu_rvalid && cpu_rdata == 8'h00);
    endproperty
    a_denied_read_zero: assert property (p_denied_read_zero) else $error("read leaked");
    property p_sfr_deny_zero;
        @(posedge pclk) disable iff (!presetn) sfr_deny |-> (sfr_rdata == 8'h00 && !sfr_fab_wr.en);
    endproperty
    a_sfr_deny_zero: assert property (p_sfr_deny_zero) else $error("denied register acted");
    property p_ptr_unreadable;
        @(posedge pclk) disable iff (!presetn) (s_rd && (is_plo || is_phi))
            |=> (sfr_rdata == 8'h00 && sfr_deny);
    endproperty
    a_ptr_unreadable: assert property (p_ptr_unreadable) else $error("pointer read back");
    property p_rng_ro;
        @(posedge pclk) disable iff (!presetn) (s_wr && is_rng) |=> (!sfr_fab_wr.en && sfr_deny);
    endproperty
    a_rng_ro: assert property (p_rng_ro) else $error("random register written");
    property p_key_wo;
        @(posedge pclk) disable iff (!presetn) (s_rd && is_key) |=> (sfr_rdata == 8'h00);
    endproperty
    a_key_wo: assert property (p_key_wo) else $error("key read back");
    property p_segcfg_closed;
        @(posedge pclk) disable iff (!presetn) (s_wr && is_plo && mode != MODE_SYSTEM)
            |=> ($stable(st_reg.ptr_lo) && sfr_deny);
    endproperty
    a_segcfg_closed: assert property (p_segcfg_closed) else $error("pointer changed");
    property p_general_open;
        @(posedge pclk) disable iff (!presetn) ((s_rd || s_wr) && g_gen) |=> !sfr_deny;
    endproperty
    a_general_open: assert property (p_general_open) else $error("general register denied");
    property p_user_dead_table;
        @(posedge pclk) disable iff (!presetn) (cpu_req.valid && mode == MODE_USER && !tbl_on)
            |=> (cpu_deny && !mem_cmd.en);
    endproperty
    a_user_dead_table: assert property (p_user_dead_table) else $error("user code ran");
    property p_cop_ram;
        @(posedge pclk) disable iff (!presetn) (cop_req.valid && cop_req.addr >= `MBAC_COPRAM_BASE)
            |=> cop_grant;
    endproperty
    a_cop_ram: assert property (p_cop_ram) else $error("coprocessor RAM refused");
endmodule
`default_nettype wire

// ### inc/mbac_regs.svh
`ifndef MBAC_REGS_SVH
`define MBAC_REGS_SVH
// APB register byte offsets
`define MBAC_A_SEG_SEL 8'h00
`define MBAC_A_SEG_FIRST 8'h04
`define MBAC_A_SEG_LAST 8'h08
`define MBAC_A_SEG_OFFSET 8'h0c
`define MBAC_A_SEG_RIGHTS 8'h10
`define MBAC_A_STATUS 8'h14
// Status field positions
`define MBAC_ST_DENY 0
`define MBAC_ST_SEG_LSB 1
`define MBAC_ST_CUR_VALID 7
`define MBAC_ST_MODE_LSB 8
// Internal mode bits
`define MBAC_MB_BOOT 2'b01
`define MBAC_MB_TEST 2'b10
`define MBAC_MB_CTLS 2'b11
`define MBAC_PROGRAM_STATUS_HIGH_SYS_BIT 7
// Segment rights bit positions
`define MBAC_RT_R 0
`define MBAC_RT_W 1
`define MBAC_RT_X 2
`define MBAC_RT_HR 3
`define MBAC_RT_HW 4
// Physical memory map
`define MBAC_TROM_END 16'h0fff
`define MBAC_AROM_BASE 16'h1000
`define MBAC_AROM_END 16'h7fff
`define MBAC_REE_BASE 16'h8000
`define MBAC_REE_END 16'h87ff
`define MBAC_AEE_BASE 16'h8800
`define MBAC_AEE_END 16'hbfff
`define MBAC_SECROW_BASE 16'h8800
`define MBAC_SECROW_END 16'h883f
`define MBAC_RAM_BASE 16'hc000
`define MBAC_RAM_END 16'hefff
`define MBAC_COPRAM_BASE 16'hf000
// Special function register addresses
`define MBAC_SFR_SP 8'h81
`define MBAC_SFR_DPL 8'h82
`define MBAC_SFR_DPH 8'h83
`define MBAC_SFR_ACC 8'he0
`define MBAC_SFR_SEGCFG_LO 8'h90
`define MBAC_SFR_SEGCFG_HI 8'h97
`define MBAC_SFR_PTR_LO 8'h91
`define MBAC_SFR_PTR_HI 8'h92
`define MBAC_SFR_TEST_LO 8'ha0
`define MBAC_SFR_TEST_HI 8'haf
`define MBAC_SFR_SYS_LO 8'hd0
`define MBAC_SFR_SYS_HI 8'hdf
`define MBAC_SFR_PROGRAM_STATUS_HIGH 8'hd1
`define MBAC_SFR_RNG 8'hc8
`define MBAC_SFR_KEY 8'hc9
// Reset values
`define MBAC_PTR_RST 8'h00
`define MBAC_PROGRAM_STATUS_HIGH_RST 8'h00
`endif

// ### inc/mbac_pkg.sv
package mbac_pkg;
    typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_CTLS, MODE_SYSTEM, MODE_USER} mbac_mode_t;
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_FETCH} mbac_op_t;
    typedef struct packed {
        logic [15:0] first;
        logic [15:0] last;
        logic [15:0] offset;
        logic [4:0] rights;
    } mbac_seg_t;
    typedef struct packed {
        logic valid;
        mbac_op_t op;
        logic [15:0] vaddr;
        logic [7:0] wdata;
    } mbac_cpu_req_t;
    typedef struct packed {
        logic en;
        logic we;
        logic fetch;
        logic [15:0] paddr;
        logic [7:0] wdata;
    } mbac_mem_cmd_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mbac_sfr_req_t;
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } mbac_sfr_wr_t;
    typedef struct packed {
        logic valid;
        logic we;
        logic [15:0] addr;
    } mbac_cop_req_t;
    typedef struct packed {
        mbac_seg_t [63:0] seg;
        logic [7:0] program_status_high;
        logic [7:0] ptr_lo;
        logic [7:0] ptr_hi;
        logic [5:0] seg_sel;
        logic [5:0] cur_seg;
        logic cur_valid;
        mbac_mem_cmd_t mem;
        logic rd_pend;
        logic rd_gate;
        logic [7:0] cpu_rdata;
        logic cpu_rvalid;
        logic cpu_deny;
        mbac_sfr_wr_t sfr_wr;
        logic [7:0] sfr_rdata;
        logic sfr_deny;
        logic cop_grant;
        logic deny_sticky;
    } mbac_state_t;
endpackage

// ### dv/mbac_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module mbac_far_model import mbac_pkg::*; (
    input wire logic pclk, // Clock
    input wire mbac_mem_cmd_t mem_cmd, // Memory command from the block
    input wire mbac_sfr_req_t sfr_req, // Register request from the core
    output logic [7:0] mem_rdata, // Memory read data
    output logic [7:0] sfr_fab_rdata // Register fabric read data
);
    logic [7:0] churn;
    initial churn = 8'h00;
    // Idle lines change every cycle so a stale value never passes for data
    always @(posedge pclk) churn <= churn + 8'h5b;
    assign mem_rdata = mem_cmd.en ? (mem_cmd.paddr[7:0] ^ 8'h5a) : churn;
    assign sfr_fab_rdata = (sfr_req.rd | sfr_req.wr) ? (sfr_req.addr ^ 8'h3c) : ~churn;
endmodule
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "mbac_regs.svh"
module tb import mbac_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, mem_rdata, cpu_rdata, sfr_fab_rdata, sfr_rdata;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] mb;
    logic cpu_rvalid, cpu_deny, sfr_deny, cop_grant;
    mbac_cpu_req_t cpu_req;
    mbac_mem_cmd_t mem_cmd;
    mbac_sfr_req_t sfr_req;
    mbac_sfr_wr_t sfr_fab_wr;
    mbac_cop_req_t cop_req;
    mbac_mode_t cpu_mode;
    int errors, comparisons, cycles;

    mbac_top mbac_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .core_mode_bits(mb), .cpu_req(cpu_req),
        .mem_cmd(mem_cmd), .mem_rdata(mem_rdata), .cpu_rdata(cpu_rdata),
        .cpu_rvalid(cpu_rvalid), .cpu_deny(cpu_deny), .sfr_req(sfr_req),
        .sfr_fab_rdata(sfr_fab_rdata), .sfr_fab_wr(sfr_fab_wr), .sfr_rdata(sfr_rdata),
        .sfr_deny(sfr_deny), .cop_req(cop_req), .cop_grant(cop_grant), .cpu_mode(cpu_mode));
    mbac_far_model mbac_far_model_i (.pclk(pclk), .mem_cmd(mem_cmd), .sfr_req(sfr_req),
        .mem_rdata(mem_rdata), .sfr_fab_rdata(sfr_fab_rdata));

    // ****************
    // Access tasks
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic set_mode(input logic [1:0] b, input mbac_mode_t m);
        @(posedge pclk);
        mb <= b;
        #1;
        chk(cpu_mode, m);
    endtask
    // Denied reads must still answer, with zero instead of memory contents
    task automatic mem_op(input mbac_op_t op, input logic [15:0] va, input logic ok,
                          input logic [15:0] pa);
        @(posedge pclk);
        cpu_req <= '{1'h1, op, va, 8'ha5};
        @(posedge pclk);
        cpu_req.valid <= 1'h0;
        #1;
        chk(mem_cmd.en, ok);
        chk(cpu_deny, !ok);
        if (ok) chk({mem_cmd.paddr, mem_cmd.we, mem_cmd.fetch, mem_cmd.wdata},
                    {pa, op == OP_WRITE, op == OP_FETCH, 8'ha5});
        if (op != OP_WRITE) begin
            @(posedge pclk);
            #1;
            chk({cpu_rvalid, cpu_rdata}, {1'h1, ok ? pa[7:0] ^ 8'h5a : 8'h00});
        end
    endtask
    task automatic sfr_op(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                          input logic ok, input logic [7:0] exp);
        @(posedge pclk);
        sfr_req <= '{!wr, wr, a, wd};
        @(posedge pclk);
        sfr_req <= '0;
        #1;
        chk(sfr_deny, !ok);
        chk(wr ? {7'h0, sfr_fab_wr.en} : sfr_rdata, exp);
        if (wr && exp[0]) chk({sfr_fab_wr.addr, sfr_fab_wr.data}, {a, wd});
    endtask
    task automatic cop_op(input logic we, input logic [15:0] a, input logic ok);
        @(posedge pclk);
        cop_req <= '{1'h1, we, a};
        @(posedge pclk);
        cop_req <= '0;
        #1;
        chk(cop_grant, ok);
    endtask

    // ****************
    // Clock, timeout and sequence
    // ****************
    initial begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, mb} = '0;
        {cpu_req, sfr_req, cop_req} = '0;
        {errors, comparisons, cycles} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        #1;
        chk(cpu_mode, MODE_USER);
        apb(1'h0, `MBAC_A_STATUS, 32'h0);
        chk(rd, 32'h400);
        mem_op(OP_FETCH, 16'h1000, 1'h0, 16'h0);
        set_mode(2'h1, MODE_BOOT);
        mem_op(OP_FETCH, 16'h0100, 1'h1, 16'h0100);
        mem_op(OP_FETCH, 16'h1000, 1'h0, 16'h0);
        mem_op(OP_WRITE, 16'h8000, 1'h1, 16'h8000);
        mem_op(OP_READ, 16'h8800, 1'h1, 16'h8800);
        mem_op(OP_WRITE, 16'h8800, 1'h0, 16'h0);
        mem_op(OP_WRITE, 16'h0100, 1'h0, 16'h0);
        mem_op(OP_WRITE, 16'hc000, 1'h1, 16'hc000);
        sfr_op(1'h1, 8'hd1, 8'h80, 1'h1, 8'h0);
        sfr_op(1'h1, 8'h91, 8'h01, 1'h0, 8'h0);
        sfr_op(1'h0, 8'hc9, 8'h00, 1'h0, 8'h0);
        sfr_op(1'h1, 8'hc8, 8'h11, 1'h0, 8'h0);
        sfr_op(1'h1, 8'ha0, 8'h22, 1'h1, 8'h1);
        sfr_op(1'h0, 8'he0, 8'h00, 1'h1, 8'hdc);
        set_mode(2'h2, MODE_TEST);
        mem_op(OP_READ, 16'h1000, 1'h1, 16'h1000);
        mem_op(OP_WRITE, 16'h8800, 1'h1, 16'h8800);
        mem_op(OP_FETCH, 16'h8000, 1'h1, 16'h8000);
        sfr_op(1'h0, 8'ha0, 8'h00, 1'h1, 8'h9c);
        set_mode(2'h3, MODE_CTLS);
        mem_op(OP_FETCH, 16'h0100, 1'h1, 16'h0100);
        mem_op(OP_READ, 16'h8800, 1'h1, 16'h8800);
        mem_op(OP_FETCH, 16'h8800, 1'h0, 16'h0);
        sfr_op(1'h0, 8'hb0, 8'h00, 1'h1, 8'h8c);
        sfr_op(1'h0, 8'hd0, 8'h00, 1'h0, 8'h0);
        sfr_op(1'h0, 8'hd1, 8'h00, 1'h1, 8'h80);
        sfr_op(1'h1, 8'hd1, 8'h00, 1'h0, 8'h0);
        sfr_op(1'h0, 8'ha0, 8'h00, 1'h0, 8'h0);
        set_mode(2'h0, MODE_SYSTEM);
        mem_op(OP_FETCH, 16'h0100, 1'h0, 16'h0);
        mem_op(OP_FETCH, 16'h1000, 1'h1, 16'h1000);
        mem_op(OP_WRITE, 16'h8000, 1'h0, 16'h0);
        mem_op(OP_WRITE, 16'h8800, 1'h1, 16'h8800);
        mem_op(OP_WRITE, 16'hc010, 1'h1, 16'hc010);
        sfr_op(1'h1, 8'h91, 8'h01, 1'h1, 8'h0);
        sfr_op(1'h0, 8'h91, 8'h00, 1'h0, 8'h0);
        sfr_op(1'h0, 8'hd0, 8'h00, 1'h1, 8'hec);
        sfr_op(1'h0, 8'ha0, 8'h00, 1'h0, 8'h0);
        apb(1'h1, `MBAC_A_SEG_SEL, 32'h1);
        apb(1'h1, `MBAC_A_SEG_FIRST, 32'h2000);
        apb(1'h1, `MBAC_A_SEG_LAST, 32'h20ff);
        apb(1'h1, `MBAC_A_SEG_OFFSET, 32'h1000);
        apb(1'h1, `MBAC_A_SEG_RIGHTS, 32'h0d);
        apb(1'h0, `MBAC_A_SEG_RIGHTS, 32'h0);
        chk(rd, 32'h0d);
        chk(er, 1'h0);
        apb(1'h0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'h1);
        sfr_op(1'h1, 8'hd1, 8'h00, 1'h1, 8'h0);
        #1;
        chk(cpu_mode, MODE_USER);
        mem_op(OP_FETCH, 16'h2010, 1'h1, 16'h3010);
        mem_op(OP_READ, 16'h2020, 1'h1, 16'h3020);
        mem_op(OP_WRITE, 16'h2010, 1'h0, 16'h0);
        mem_op(OP_FETCH, 16'h4000, 1'h0, 16'h0);
        apb(1'h0, `MBAC_A_STATUS, 32'h0);
        chk(rd[10:1], {3'h4, 1'h1, 6'h1});
        sfr_op(1'h0, 8'hb0, 8'h00, 1'h1, 8'h8c);
        sfr_op(1'h1, 8'hb0, 8'h33, 1'h0, 8'h0);
        sfr_op(1'h0, 8'hd1, 8'h00, 1'h1, 8'h00);
        sfr_op(1'h1, 8'h91, 8'h00, 1'h0, 8'h0);
        sfr_op(1'h0, 8'he0, 8'h00, 1'h1, 8'hdc);
        cop_op(1'h0, 16'h8000, 1'h1);
        cop_op(1'h1, 16'h8000, 1'h0);
        cop_op(1'h1, 16'hf000, 1'h1);
        cop_op(1'h0, 16'h1000, 1'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
